// ---- verilog/mmdec_decoder.sv ----
/*
 Memory map address decoder: one registered decode per bus request.
 Assumes requests are synchronous to clk and that the vector table
 base comes from the core, already 20 bits wide.
*/
// Notes on behaviour
// R1: Addresses 00000h-003FFh and 0D000h-0D7FFh go to the peripheral area.
// R2: Masters must not touch reserved gaps inside the peripheral ranges.
// R3: Internal RAM of 10 KB answers at 00400h through 02BFFh.
// R4: RAM also takes stack pushes from calls and accepted interrupts.
// R5: Data flash answers at 0E000h through 0FFFFh.
// R6: Data flash accepts instruction fetches as well as data reads.
// R7: The second program flash answers at 10000h through 13FFFh.
// R8: The first program flash, 64 KB, answers at F0000h through FFFFFh.
// R9: FFE00h-FFFD7h are flagged as the special page vector range.
// R10: FFFDCh-FFFFFh are flagged as the fixed interrupt vector table.
// R11: 256 bytes from the vector table base form the relocatable table.
// R12: The vector table base is 20 bits wide.
// R13: The request address is 20 bits wide.
// R14: Unmatched addresses go external in expansion mode, else unmapped.
`timescale 1ns/100ps
module mmdec_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire mmdec_pkg::mmdec_req_t req, // R13
    input wire logic [19:0] vector_table_base, // R12
    input wire logic expansion_mode,
    output mmdec_pkg::mmdec_sel_t sel
);
    mmdec_pkg::mmdec_state_t state;
    mmdec_pkg::mmdec_state_t next_state;

    function automatic logic in_range(input logic [19:0] a,
        input logic [19:0] lo, input logic [19:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // Decode is pure compare logic; registering it keeps the output
    // glitch free at the cost of one cycle of latency.
    always_comb begin
        logic [20:0] reloc_end;
        reloc_end = {1'b0, vector_table_base} + {1'b0, mmdec_pkg::VEC_SPAN};
        next_state = '0;
        next_state.sel.valid = req.valid;
        next_state.sel.region = mmdec_pkg::MMDEC_NONE;
        if (in_range(req.addr, mmdec_pkg::PERI_LO_START,
                mmdec_pkg::PERI_LO_END)) begin
            next_state.sel.region = mmdec_pkg::MMDEC_PERI; // R1
            next_state.sel.offset = req.addr - mmdec_pkg::PERI_LO_START;
        end else if (in_range(req.addr, mmdec_pkg::PERI_HI_START,
                mmdec_pkg::PERI_HI_END)) begin
            next_state.sel.region = mmdec_pkg::MMDEC_PERI; // R1
            next_state.sel.offset = req.addr - mmdec_pkg::PERI_HI_START;
        end else if (in_range(req.addr, mmdec_pkg::RAM_START,
                mmdec_pkg::RAM_END)) begin
            // Stack pushes and data use the same path. R4
            next_state.sel.region = mmdec_pkg::MMDEC_RAM; // R3
            next_state.sel.offset = req.addr - mmdec_pkg::RAM_START;
        end else if (in_range(req.addr, mmdec_pkg::DFLASH_START,
                mmdec_pkg::DFLASH_END)) begin
            // Fetches are not filtered here. R6
            next_state.sel.region = mmdec_pkg::MMDEC_DFLASH; // R5
            next_state.sel.offset = req.addr - mmdec_pkg::DFLASH_START;
        end else if (in_range(req.addr, mmdec_pkg::PROG2_START,
                mmdec_pkg::PROG2_END)) begin
            next_state.sel.region = mmdec_pkg::MMDEC_PROG2; // R7
            next_state.sel.offset = req.addr - mmdec_pkg::PROG2_START;
        end else if (in_range(req.addr, mmdec_pkg::PROG1_START,
                mmdec_pkg::PROG1_END)) begin
            next_state.sel.region = mmdec_pkg::MMDEC_PROG1; // R8
            next_state.sel.offset = req.addr - mmdec_pkg::PROG1_START;
        end else if (expansion_mode) begin
            next_state.sel.region = mmdec_pkg::MMDEC_EXT; // R14
            next_state.sel.offset = req.addr;
        end else begin
            next_state.sel.unmapped = req.valid; // R14
        end
        next_state.sel.spage_vec = in_range(req.addr,
            mmdec_pkg::SPAGE_START, mmdec_pkg::SPAGE_END); // R9
        next_state.sel.fix_vec = in_range(req.addr,
            mmdec_pkg::FIXVEC_START, mmdec_pkg::FIXVEC_END); // R10
        // A base near the top would wrap; the table is then not flagged
        // above FFFFFh, a limitation software must avoid.
        next_state.sel.reloc_vec = (req.addr >= vector_table_base) &&
            ({1'b0, req.addr} <= reloc_end); // R11
        // Stack pushes outside RAM or instruction fetches from the peripheral area are flagged.
        next_state.sel.bad_access = req.valid &&
            ((req.stack &&
              (next_state.sel.region != mmdec_pkg::MMDEC_RAM)) ||
             (req.fetch &&
              (next_state.sel.region == mmdec_pkg::MMDEC_PERI)));
    end

    // State register.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sel = state.sel;

    // Checks below compare each registered answer with the request taken
    // one edge earlier. They leave out the reset edges themselves, since
    // sel is all zero there and carries no legal region code.
    AST_PERI_LO: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (req.valid && req.addr <= mmdec_pkg::PERI_LO_END) |=>
        sel.region == mmdec_pkg::MMDEC_PERI)
        else $error("low peripheral address not routed");
    AST_RAM: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (req.addr >= mmdec_pkg::RAM_START && req.addr <= mmdec_pkg::RAM_END)
        |=> sel.region == mmdec_pkg::MMDEC_RAM)
        else $error("ram address not routed");
    AST_STACK: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (req.valid && req.stack && req.addr >= mmdec_pkg::RAM_START &&
         req.addr <= mmdec_pkg::RAM_END) |=> !sel.bad_access)
        else $error("stack push in ram flagged");
    AST_DFLASH: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (req.addr >= mmdec_pkg::DFLASH_START &&
         req.addr <= mmdec_pkg::DFLASH_END) |=>
        sel.region == mmdec_pkg::MMDEC_DFLASH)
        else $error("data flash address not routed");
    AST_FETCH: assert property (@(posedge clk) disable iff (!rst_n) // R6
        (req.valid && req.fetch && !req.stack &&
         req.addr >= mmdec_pkg::DFLASH_START &&
         req.addr <= mmdec_pkg::DFLASH_END) |=> !sel.bad_access)
        else $error("fetch from data flash refused");
    AST_PROG2: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (req.addr >= mmdec_pkg::PROG2_START &&
         req.addr <= mmdec_pkg::PROG2_END) |=>
        sel.region == mmdec_pkg::MMDEC_PROG2)
        else $error("second program flash not routed");
    AST_PROG1: assert property (@(posedge clk) disable iff (!rst_n) // R8
        (req.addr >= mmdec_pkg::PROG1_START) |=>
        sel.region == mmdec_pkg::MMDEC_PROG1)
        else $error("first program flash not routed");
    AST_SPAGE: assert property (@(posedge clk) disable iff (!rst_n) // R9
        sel.spage_vec |-> $past(req.addr) <= mmdec_pkg::SPAGE_END &&
        $past(req.addr) >= mmdec_pkg::SPAGE_START)
        else $error("special page flag out of range");
    AST_FIXVEC: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (req.addr >= mmdec_pkg::FIXVEC_START) |=> sel.fix_vec)
        else $error("fixed vector flag missing");
    AST_RELOC: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (req.addr == vector_table_base) |=> sel.reloc_vec)
        else $error("relocatable table base not flagged");
    AST_EXT: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (req.valid && req.addr > mmdec_pkg::PROG2_END &&
         req.addr < mmdec_pkg::PROG1_START) |=>
        (sel.region == mmdec_pkg::MMDEC_EXT) == $past(expansion_mode) &&
        sel.unmapped == !$past(expansion_mode))
        else $error("unmatched address handled wrongly");

    // Upper peripheral window and the offsets handed to the regions. The
    // offset is the local address of the selected array, so a wrong base
    // subtraction would corrupt data without any other symptom.
    AST_PERI_HI: assert property (@(posedge clk) disable iff (!rst_n) // R1
        (req.addr >= mmdec_pkg::PERI_HI_START &&
         req.addr <= mmdec_pkg::PERI_HI_END) |=>
        sel.region == mmdec_pkg::MMDEC_PERI &&
        sel.offset == $past(req.addr) - mmdec_pkg::PERI_HI_START)
        else $error("high peripheral address not routed");
    AST_RAM_OFS: assert property (@(posedge clk) disable iff (!rst_n) // R3
        (req.addr >= mmdec_pkg::RAM_START && req.addr <= mmdec_pkg::RAM_END)
        |=> sel.offset == $past(req.addr) - mmdec_pkg::RAM_START)
        else $error("ram offset wrong");
    AST_DFLASH_OFS: assert property (@(posedge clk) disable iff (!rst_n) // R5
        (req.addr >= mmdec_pkg::DFLASH_START &&
         req.addr <= mmdec_pkg::DFLASH_END) |=>
        sel.offset == $past(req.addr) - mmdec_pkg::DFLASH_START)
        else $error("data flash offset wrong");
    AST_PROG2_OFS: assert property (@(posedge clk) disable iff (!rst_n) // R7
        (req.addr >= mmdec_pkg::PROG2_START &&
         req.addr <= mmdec_pkg::PROG2_END) |=>
        sel.offset == $past(req.addr) - mmdec_pkg::PROG2_START)
        else $error("second program flash offset wrong");
    AST_PROG1_OFS: assert property (@(posedge clk) disable iff (!rst_n) // R8
        (req.addr >= mmdec_pkg::PROG1_START) |=>
        sel.offset == $past(req.addr) - mmdec_pkg::PROG1_START)
        else $error("first program flash offset wrong");

    // Stack pushes that miss RAM are reported, not blocked; the master
    // that issued them has to decide how to recover.
    AST_STACK_OUT: assert property (@(posedge clk) disable iff (!rst_n) // R4
        (req.valid && req.stack &&
         !(req.addr >= mmdec_pkg::RAM_START &&
           req.addr <= mmdec_pkg::RAM_END)) |=> sel.bad_access)
        else $error("stack push outside ram not flagged");

    // An idle bus must never raise the error flags, and a request must
    // always land in exactly one region.
    AST_IDLE: assert property (@(posedge clk) disable iff (!rst_n) // R14
        !req.valid |=> !sel.valid && !sel.unmapped && !sel.bad_access)
        else $error("flags raised without a request");
    AST_VALID: assert property (@(posedge clk) disable iff (!rst_n) // R14
        req.valid |=> sel.valid && $onehot(sel.region))
        else $error("request lost or region code not one-hot");

    // Holes in the map: external accesses keep the full address, while an
    // unmapped access carries no offset at all.
    AST_EXT_OFS: assert property (@(posedge clk) disable iff (!rst_n) // R14
        (req.valid && expansion_mode && req.addr > mmdec_pkg::PROG2_END &&
         req.addr < mmdec_pkg::PROG1_START) |=>
        sel.offset == $past(req.addr))
        else $error("external offset wrong");
    AST_NONE_OFS: assert property (@(posedge clk) disable iff (!rst_n) // R14
        sel.unmapped |-> sel.region == mmdec_pkg::MMDEC_NONE && sel.offset == '0)
        else $error("unmapped access carries a region");

    // The vector overlays are checked on both sides of each bound.
    AST_SPAGE_SET: assert property (@(posedge clk) disable iff (!rst_n) // R9
        (req.addr >= mmdec_pkg::SPAGE_START &&
         req.addr <= mmdec_pkg::SPAGE_END) |=> sel.spage_vec)
        else $error("special page flag missing");
    AST_FIX_CLR: assert property (@(posedge clk) disable iff (!rst_n) // R10
        (req.addr < mmdec_pkg::FIXVEC_START) |=> !sel.fix_vec)
        else $error("fixed vector flag raised below the table");
    AST_RELOC_END: assert property (@(posedge clk) disable iff (!rst_n) // R11
        ({1'b0, req.addr} ==
         {1'b0, vector_table_base} + {1'b0, mmdec_pkg::VEC_SPAN}) |=>
        sel.reloc_vec)
        else $error("last byte of relocatable table not flagged");
    AST_RELOC_OUT: assert property (@(posedge clk) disable iff (!rst_n) // R11
        (req.addr < vector_table_base ||
         {1'b0, req.addr} > {1'b0, vector_table_base} +
         {1'b0, mmdec_pkg::VEC_SPAN}) |=> !sel.reloc_vec)
        else $error("relocatable flag raised outside the table");
endmodule

// ---- pkg/mmdec_pkg.sv ----
/*
 Package for the memory map address decoder: region bounds, region
 codes and the packed structs that carry a request and its decode.
 Assumes a 20-bit byte address space of 1 MB.
*/
package mmdec_pkg;
    localparam int ADDR_W = 20;
    localparam int VEC_TABLE_BYTES = 256;
    localparam logic [19:0] PERI_LO_START = 20'h00000;
    localparam logic [19:0] PERI_LO_END = 20'h003ff;
    localparam logic [19:0] PERI_HI_START = 20'h0d000;
    localparam logic [19:0] PERI_HI_END = 20'h0d7ff;
    localparam logic [19:0] RAM_START = 20'h00400;
    localparam logic [19:0] RAM_END = 20'h02bff;
    localparam logic [19:0] DFLASH_START = 20'h0e000;
    localparam logic [19:0] DFLASH_END = 20'h0ffff;
    localparam logic [19:0] PROG2_START = 20'h10000;
    localparam logic [19:0] PROG2_END = 20'h13fff;
    localparam logic [19:0] PROG1_START = 20'hf0000;
    localparam logic [19:0] PROG1_END = 20'hfffff;
    localparam logic [19:0] SPAGE_START = 20'hffe00;
    localparam logic [19:0] SPAGE_END = 20'hfffd7;
    localparam logic [19:0] FIXVEC_START = 20'hfffdc;
    localparam logic [19:0] FIXVEC_END = 20'hfffff;
    localparam logic [19:0] VEC_SPAN = 20'h000ff;

    // One-hot region codes.
    typedef enum logic [6:0] {
        MMDEC_NONE = 7'h01,
        MMDEC_PERI = 7'h02,
        MMDEC_RAM = 7'h04,
        MMDEC_DFLASH = 7'h08,
        MMDEC_PROG2 = 7'h10,
        MMDEC_PROG1 = 7'h20,
        MMDEC_EXT = 7'h40
    } mmdec_region_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic fetch;
        logic stack;
        logic [19:0] addr;
    } mmdec_req_t;

    typedef struct packed {
        logic valid;
        mmdec_region_t region;
        logic [19:0] offset;
        logic spage_vec;
        logic fix_vec;
        logic reloc_vec;
        logic unmapped;
        logic bad_access;
    } mmdec_sel_t;

    typedef struct packed {
        mmdec_sel_t sel;
    } mmdec_state_t;
endpackage

// ---- tb/mmdec_cpu_model.sv ----
/*
 Bus master model standing for the core: it issues decode requests.
 Assumes the bench calls access() once per request it wants decoded.
*/
`timescale 1ns/100ps
module mmdec_cpu_model (
    input wire logic clk,
    output mmdec_pkg::mmdec_req_t req
);
    // Quiet bus at time zero so the decoder never samples unknowns.
    initial req = '0;

    // Drive after the falling edge; the request then holds until replaced.
    // Callers never aim at reserved gaps in the peripheral area.
    task automatic access(input logic [19:0] a, input logic [1:0] fs);
        @(negedge clk);
        req <= '{valid: 1'b1, write: 1'b0, fetch: fs[1], stack: fs[0],
            addr: a};
    endtask
endmodule

// ---- tb/testbench.sv ----
/*
 Self-checking bench for the memory map decoder.
 Assumes sel answers at the edge that takes a request, half a cycle before it is read.
*/
`timescale 1ns/100ps
module testbench;
    localparam mmdec_pkg::mmdec_region_t rg_none = mmdec_pkg::MMDEC_NONE;
    localparam mmdec_pkg::mmdec_region_t rg_peri = mmdec_pkg::MMDEC_PERI;
    localparam mmdec_pkg::mmdec_region_t rg_ram = mmdec_pkg::MMDEC_RAM;
    localparam mmdec_pkg::mmdec_region_t rg_df = mmdec_pkg::MMDEC_DFLASH;
    localparam mmdec_pkg::mmdec_region_t rg_p2 = mmdec_pkg::MMDEC_PROG2;
    localparam mmdec_pkg::mmdec_region_t rg_p1 = mmdec_pkg::MMDEC_PROG1;
    localparam mmdec_pkg::mmdec_region_t rg_ext = mmdec_pkg::MMDEC_EXT;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [19:0] vector_table_base = 20'h02000;
    logic expansion_mode = 1'b0;
    mmdec_pkg::mmdec_req_t req;
    mmdec_pkg::mmdec_sel_t sel;
    int n_errors = 0;
    int checked = 0;

    // A 50 ns half period gives the 10 MHz bus clock.
    always #50 clk = ~clk;

    mmdec_cpu_model cpu (.clk(clk), .req(req));
    mmdec_decoder dut (.clk(clk), .rst_n(rst_n), .req(req),
        .vector_table_base(vector_table_base),
        .expansion_mode(expansion_mode), .sel(sel));

    // Flags are spage, fix, reloc, unmapped, bad in that order.
    task automatic probe(input logic [19:0] a, input logic [1:0] fs,
            input logic [6:0] xr, input logic [19:0] xo, input logic [4:0] xf);
        logic [32:0] got;
        logic [32:0] exp;
        cpu.access(a, fs);
        @(negedge clk);
        got = {sel.valid, sel.region, sel.offset, sel.spage_vec,
            sel.fix_vec, sel.reloc_vec, sel.unmapped, sel.bad_access};
        exp = {1'b1, xr, xo, xf};
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Both edges of the low peripheral window and the second program flash, one edge of the others; a new request every two cycles.
    task automatic test_regions();
        probe(20'h00000, 2'h0, rg_peri, 20'h00000, 5'h00);
        probe(20'h003ff, 2'h0, rg_peri, 20'h003ff, 5'h00);
        probe(20'h0d7ff, 2'h0, rg_peri, 20'h007ff, 5'h00);
        probe(20'h00400, 2'h0, rg_ram, 20'h00000, 5'h00);
        probe(20'h0ffff, 2'h0, rg_df, 20'h01fff, 5'h00);
        probe(20'h10000, 2'h0, rg_p2, 20'h00000, 5'h00);
        probe(20'h13fff, 2'h0, rg_p2, 20'h03fff, 5'h00);
        probe(20'hf0000, 2'h0, rg_p1, 20'h00000, 5'h00);
        $display("test_regions done, errors %0d", n_errors);
    endtask

    // Vector overlays, with the table base moved to the top of memory.
    task automatic test_vectors();
        probe(20'hffe00, 2'h0, rg_p1, 20'h0fe00, 5'h10);
        probe(20'hfffd7, 2'h0, rg_p1, 20'h0ffd7, 5'h10);
        probe(20'hfffd8, 2'h0, rg_p1, 20'h0ffd8, 5'h00);
        probe(20'h01fff, 2'h0, rg_ram, 20'h01bff, 5'h00);
        probe(20'h02000, 2'h0, rg_ram, 20'h01c00, 5'h04);
        probe(20'h020ff, 2'h0, rg_ram, 20'h01cff, 5'h04);
        probe(20'h02100, 2'h0, rg_ram, 20'h01d00, 5'h00);
        vector_table_base = 20'hfff00;
        probe(20'hfffdc, 2'h0, rg_p1, 20'h0ffdc, 5'h0c);
        probe(20'hfffff, 2'h0, rg_p1, 20'h0ffff, 5'h0c);
        $display("test_vectors done, errors %0d", n_errors);
    endtask

    // Stack pushes and instruction fetches, legal and misplaced.
    task automatic test_access();
        probe(20'h02bff, 2'h1, rg_ram, 20'h027ff, 5'h00);
        probe(20'h0e000, 2'h1, rg_df, 20'h00000, 5'h01);
        probe(20'h0e000, 2'h2, rg_df, 20'h00000, 5'h00);
        probe(20'h00100, 2'h2, rg_peri, 20'h00100, 5'h01);
        $display("test_access done, errors %0d", n_errors);
    endtask

    // Holes in the map, first unmapped, then sent to the external bus.
    task automatic test_unmapped();
        probe(20'h0d800, 2'h0, rg_none, 20'h00000, 5'h02);
        probe(20'h02c00, 2'h0, rg_none, 20'h00000, 5'h02);
        probe(20'h20000, 2'h0, rg_none, 20'h00000, 5'h02);
        expansion_mode = 1'b1;
        probe(20'h02c00, 2'h0, rg_ext, 20'h02c00, 5'h00);
        probe(20'h14000, 2'h0, rg_ext, 20'h14000, 5'h00);
        probe(20'hefff0, 2'h0, rg_ext, 20'hefff0, 5'h00);
        $display("test_unmapped done, errors %0d", n_errors);
    endtask

    // Reset in mid-run clears sel at once, then decoding resumes.
    task automatic test_reset();
        logic [32:0] got;
        cpu.access(20'hfffe0, 2'h0);
        rst_n = 1'b0;
        @(negedge clk);
        got = sel;
        checked++;
        if (got !== 33'h0) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, 33'h0);
        end
        rst_n = 1'b1;
        probe(20'hfffe0, 2'h0, rg_p1, 20'h0ffe0, 5'h0c);
        $display("test_reset done, errors %0d", n_errors);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Reset spans six cycles and is released on a falling edge.
    initial begin
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        test_regions();
        test_vectors();
        test_access();
        test_unmapped();
        test_reset();
        print_verdict();
    end

    // About 64 cycles are needed; 5000 means the bench has hung.
    initial begin
        #500000;
        n_errors++;
        print_verdict();
    end
endmodule
